/* sac_pkg.sv */
// Constants and types of the serial converter control block
// Operation
// - A rising edge on the conversion start strobe while the clock is high begins a new conversion.
// - Timing violations may lock out requests; a nap request restores normal response.
// - Every conversion yields a 12-bit result word with no missing codes.
// - After nap wake-up the device is ready within about 350 ns.
// - A clock pulse of at least 50 ns wakes the device from power-down.
// - Bipolar results are two's complement around zero.
// - Device returns to sample mode about 80 ns after a rising clock edge.
// - With clock low, two strobe pulses request nap, four request sleep.
// - Start strobes are ignored mid-conversion; the approximation register clears at start.
// - The result shifts out serially, synchronised to the host clock.
package sac_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int SAC_CLK_PERIOD_NS = 100;
  localparam int SAC_WAKE_NAP_NS   = 350;
  localparam int SAC_TRACK_NS      = 80;
  localparam int SAC_WAKE_PULSE_NS = 50;
  // Longest times round down, at least one cycle
  localparam int SAC_WAKE_NAP_CYC  = (SAC_WAKE_NAP_NS / SAC_CLK_PERIOD_NS) < 1 ? 1 :
                                     (SAC_WAKE_NAP_NS / SAC_CLK_PERIOD_NS);
  localparam int SAC_TRACK_CYC     = (SAC_TRACK_NS / SAC_CLK_PERIOD_NS) < 1 ? 1 :
                                     (SAC_TRACK_NS / SAC_CLK_PERIOD_NS);
  // Least time rounds up
  localparam int SAC_WAKE_PULSE_CYC = (SAC_WAKE_PULSE_NS + SAC_CLK_PERIOD_NS - 1) / SAC_CLK_PERIOD_NS;
  // ************************************************************
  // Format
  // ************************************************************
  localparam int SAC_RES_BITS     = 12;
  localparam int SAC_NAP_PULSES   = 2;
  localparam int SAC_SLEEP_PULSES = 4;
  // Idle levels of the link pins, loaded into the synchronisers at reset
  localparam logic SAC_STROBE_IDLE = 1'b0;
  localparam logic SAC_CLK_IDLE    = 1'b1;
  localparam int SAC_CNT_W        = 4;
  localparam logic [SAC_RES_BITS-1:0] SAC_RESULT_RST = 12'h000;
  localparam logic [SAC_RES_BITS-1:0] SAC_SIGN_FLIP  = 12'h800;
  // ************************************************************
  // States
  // ************************************************************
  typedef enum logic [4:0] {
    SAC_ST_TRACK = 5'h01,
    SAC_ST_CONVERSION_START_STROBE  = 5'h02,
    SAC_ST_NAP   = 5'h04,
    SAC_ST_SLEEP = 5'h08,
    SAC_ST_WAKE  = 5'h10
  } sac_state_t;
endpackage

/* sac_sync.sv */
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
module sac_sync #(
  parameter logic IDLE = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Pin in, clean level and edges out
  input  wire logic pin_raw,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  always_ff @(posedge clk_sys) begin
    // Reset to the idle level, so no false edge follows reset
    if (rst) begin
      meta_ff <= IDLE;
      sync_ff <= IDLE;
      prev_ff <= IDLE;
    end else begin
      meta_ff <= pin_raw;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~prev_ff;
  assign fall  = ~sync_ff & prev_ff;
endmodule

/* sac_top.sv */
// Conversion control and serial readout of the 12-bit converter
`timescale 1ns/100ps
module sac_top #(
  parameter int RES_BITS = sac_pkg::SAC_RES_BITS
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Link pins from the host
  input  wire logic                conversion_start_strobe,
  input  wire logic                link_clk,
  // Serial result pin, three-state
  output logic                     dout_data,
  output logic                     dout_oe,
  // Converter core side
  input  wire logic                bipolar_mode,
  input  wire logic                cmp_decision,
  output logic [RES_BITS-1:0]      dac_code,
  output logic                     track_mode,
  output logic                     nap_mode,
  output logic                     sleep_mode,
  output logic                     conversion_start_strobe_busy,
  output logic                     result_valid,
  output logic [RES_BITS-1:0]      result_word
);
  import sac_pkg::*;

  // Counters and sign flip constant serve one word width only
  if (RES_BITS != SAC_RES_BITS) begin : g_bad_width
    $error("RES_BITS must equal 12");
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic strobe_rise, strobe_fall;
  logic clk_lvl, clk_rise, clk_fall;

  sac_sync #(
    .IDLE (SAC_STROBE_IDLE)
  ) u_sync_strobe (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_raw (conversion_start_strobe),
    .level   (),
    .rise    (strobe_rise),
    .fall    (strobe_fall)
  );

  sac_sync #(
    .IDLE (SAC_CLK_IDLE)
  ) u_sync_clk (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_raw (link_clk),
    .level   (clk_lvl),
    .rise    (clk_rise),
    .fall    (clk_fall)
  );

  // ************************************************************
  // State and counters
  // ************************************************************
  sac_state_t                state_ff, nxt_state;
  logic [SAC_CNT_W-1:0]      bit_ff, nxt_bit;
  logic [SAC_CNT_W-1:0]      pulse_ff, nxt_pulse;
  logic [SAC_CNT_W-1:0]      wait_ff, nxt_wait;
  logic [SAC_CNT_W-1:0]      hi_ff, nxt_hi;
  logic [RES_BITS-1:0]       sar_ff, nxt_sar;
  logic [RES_BITS-1:0]       shift_ff, nxt_shift;
  logic [RES_BITS-1:0]       res_ff, nxt_res;
  logic                      oe_ff, nxt_oe;
  logic                      dout_ff, nxt_dout;
  logic                      track_ff, nxt_track;
  logic                      rv_ff, nxt_rv;
  logic [SAC_CNT_W-1:0]      shift_left_ff, nxt_shift_left;

  // Decode
  wire st_track = (state_ff == SAC_ST_TRACK);
  wire st_conversion_start_strobe  = (state_ff == SAC_ST_CONVERSION_START_STROBE);
  wire st_down  = (state_ff == SAC_ST_NAP) || (state_ff == SAC_ST_SLEEP);
  wire st_nap   = (state_ff == SAC_ST_NAP);
  wire last_bit = (bit_ff == SAC_CNT_W'(RES_BITS - 1));
  wire [RES_BITS-1:0] bit_mask = RES_BITS'(1) << (RES_BITS - 1 - int'(bit_ff));
  wire [RES_BITS-1:0] trial    = sar_ff | bit_mask;
  wire [RES_BITS-1:0] decided  = cmp_decision ? trial : sar_ff;
  // Bipolar: flip MSB of offset binary to two's complement
  wire [RES_BITS-1:0] coded    = bipolar_mode ? (decided ^ SAC_SIGN_FLIP) : decided;
  // Power-down counting only while the link clock rests low
  // Nap keeps counting, so pulses three and four deepen it into sleep
  wire pd_pulse  = strobe_rise & ~clk_lvl & (st_track | st_conversion_start_strobe | st_nap);
  wire pd_fall   = strobe_fall & ~clk_lvl;
  wire wake_ok   = clk_fall & (hi_ff >= SAC_CNT_W'(SAC_WAKE_PULSE_CYC));

  always_comb begin
    nxt_state      = state_ff;
    nxt_bit        = bit_ff;
    nxt_pulse      = pulse_ff;
    nxt_wait       = wait_ff;
    nxt_sar        = sar_ff;
    nxt_shift      = shift_ff;
    nxt_res        = res_ff;
    nxt_oe         = oe_ff;
    nxt_dout       = dout_ff;
    nxt_track      = track_ff;
    nxt_rv         = 1'b0;
    nxt_shift_left = shift_left_ff;
    nxt_hi         = clk_lvl ? ((hi_ff == '1) ? hi_ff : hi_ff + 1'b1) : '0;
    // Clock activity ends a power-down request sequence
    if (clk_rise) nxt_pulse = '0;
    // serial out, MSB first on rising link clock
    if (clk_rise && shift_left_ff != '0) begin
      nxt_dout       = shift_ff[RES_BITS-1];
      nxt_shift      = {shift_ff[RES_BITS-2:0], 1'b0};
      nxt_shift_left = shift_left_ff - 1'b1;
      nxt_oe         = 1'b1;
    end else if (clk_rise && oe_ff) begin
      nxt_oe = 1'b0;
    end
    case (state_ff)
      SAC_ST_TRACK: begin
        // back to sample mode after rising link clock
        if (clk_rise) nxt_track = 1'b1;
        // rising strobe starts conversion, SAR cleared
        if (strobe_rise && clk_lvl) begin
          nxt_state = SAC_ST_CONVERSION_START_STROBE;
          nxt_sar   = '0;
          nxt_bit   = '0;
          nxt_track = 1'b0;
          nxt_pulse = '0;
        end
      end
      SAC_ST_CONVERSION_START_STROBE: begin
        // start strobes ignored here; one decision per link clock
        if (clk_rise) begin
          nxt_sar = decided;
          nxt_bit = bit_ff + 1'b1;
          if (last_bit) begin
            nxt_res        = coded;
            nxt_shift      = coded;
            nxt_shift_left = SAC_CNT_W'(RES_BITS);
            nxt_rv         = 1'b1;
            // sample mode follows the final rising clock
            nxt_track      = 1'b1;
            nxt_state      = SAC_ST_TRACK;
          end
        end
      end
      SAC_ST_NAP, SAC_ST_SLEEP: begin
        nxt_track = 1'b0;
        // fourth pulse end turns nap into sleep
        if (st_nap && pd_fall && pulse_ff == SAC_CNT_W'(SAC_SLEEP_PULSES)) begin
          nxt_state = SAC_ST_SLEEP;
          nxt_pulse = '0;
        end
        if (wake_ok) begin
          nxt_state = SAC_ST_WAKE;
          nxt_wait  = '0;
        end
      end
      SAC_ST_WAKE: begin
        nxt_wait = wait_ff + 1'b1;
        if (wait_ff >= SAC_CNT_W'(SAC_WAKE_NAP_CYC - 1)) begin
          nxt_state = SAC_ST_TRACK;
          nxt_track = 1'b1;
          nxt_pulse = '0;
        end
      end
      default: nxt_state = SAC_ST_TRACK;
    endcase
    // nap request taken at second pulse end, from track or conversion state
    if (pd_fall && pulse_ff == SAC_CNT_W'(SAC_NAP_PULSES) && (st_track || st_conversion_start_strobe)) begin
      nxt_state = SAC_ST_NAP;
    end
    // pulses counted in conversion too, so a stuck converter can recover
    if (pd_pulse) nxt_pulse = pulse_ff + 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff      <= SAC_ST_TRACK;
      bit_ff        <= '0;
      pulse_ff      <= '0;
      wait_ff       <= '0;
      hi_ff         <= '0;
      sar_ff        <= '0;
      shift_ff      <= '0;
      res_ff        <= SAC_RESULT_RST;
      oe_ff         <= 1'b0;
      dout_ff       <= 1'b0;
      track_ff      <= 1'b1;
      rv_ff         <= 1'b0;
      shift_left_ff <= '0;
    end else begin
      state_ff      <= nxt_state;
      bit_ff        <= nxt_bit;
      pulse_ff      <= nxt_pulse;
      wait_ff       <= nxt_wait;
      hi_ff         <= nxt_hi;
      sar_ff        <= nxt_sar;
      shift_ff      <= nxt_shift;
      res_ff        <= nxt_res;
      oe_ff         <= nxt_oe;
      dout_ff       <= nxt_dout;
      track_ff      <= nxt_track;
      rv_ff         <= nxt_rv;
      shift_left_ff <= nxt_shift_left;
    end
  end

  assign dout_data    = dout_ff;
  assign dout_oe      = oe_ff;
  assign dac_code     = trial;
  assign track_mode   = track_ff;
  assign nap_mode     = (state_ff == SAC_ST_NAP);
  assign sleep_mode   = (state_ff == SAC_ST_SLEEP);
  assign conversion_start_strobe_busy    = st_conversion_start_strobe;
  assign result_valid = rv_ff;
  assign result_word  = res_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_start;
    @(posedge clk_sys) disable iff (rst) st_track && strobe_rise && clk_lvl |=> conversion_start_strobe_busy && sar_ff == '0;
  endproperty
  a_start: assert property (p_start) else $error("strobe rise did not start conversion");

  property p_no_restart;
    @(posedge clk_sys) disable iff (rst) st_conversion_start_strobe && !clk_rise |=> $stable(bit_ff) && $stable(sar_ff);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion restarted");

  property p_done;
    @(posedge clk_sys) disable iff (rst) st_conversion_start_strobe && clk_rise && last_bit && !strobe_fall
      |=> result_valid && st_track && shift_left_ff == SAC_CNT_W'(RES_BITS);
  endproperty
  a_done: assert property (p_done) else $error("result word not produced");

  property p_wake;
    @(posedge clk_sys) disable iff (rst) state_ff == SAC_ST_WAKE |-> ##[1:4] st_track;
  endproperty
  a_wake: assert property (p_wake) else $error("nap wake too slow");

  property p_pulse_wake;
    @(posedge clk_sys) disable iff (rst) st_down && wake_ok |=> state_ff == SAC_ST_WAKE;
  endproperty
  a_pulse_wake: assert property (p_pulse_wake) else $error("clock pulse did not wake");

  property p_bipolar;
    @(posedge clk_sys) disable iff (rst) result_valid && $past(bipolar_mode)
      |-> result_word == ($past(decided) ^ SAC_SIGN_FLIP);
  endproperty
  a_bipolar: assert property (p_bipolar) else $error("bipolar coding wrong");

  property p_track;
    @(posedge clk_sys) disable iff (rst) st_track && clk_rise && !strobe_rise |=> track_mode;
  endproperty
  a_track: assert property (p_track) else $error("no return to sample mode");

  property p_track_end;
    @(posedge clk_sys) disable iff (rst) st_conversion_start_strobe && clk_rise && last_bit |=> track_mode;
  endproperty
  a_track_end: assert property (p_track_end) else $error("no sample mode after conversion");

  property p_nap;
    @(posedge clk_sys) disable iff (rst) (st_track || st_conversion_start_strobe) && pd_fall
      && pulse_ff == SAC_CNT_W'(SAC_NAP_PULSES) |=> nap_mode;
  endproperty
  a_nap: assert property (p_nap) else $error("nap request missed");

  property p_sleep;
    @(posedge clk_sys) disable iff (rst) st_nap && pd_fall
      && pulse_ff == SAC_CNT_W'(SAC_SLEEP_PULSES) |=> sleep_mode;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep request missed");

  property p_shift;
    @(posedge clk_sys) disable iff (rst) clk_rise && shift_left_ff != '0
      |=> dout_oe && dout_data == $past(shift_ff[RES_BITS-1]);
  endproperty
  a_shift: assert property (p_shift) else $error("serial bit wrong");

  c_conversion_start_strobe:  cover property (@(posedge clk_sys) disable iff (rst) result_valid);
  c_nap:   cover property (@(posedge clk_sys) disable iff (rst) nap_mode);
  c_sleep: cover property (@(posedge clk_sys) disable iff (rst) sleep_mode);
  c_wake:  cover property (@(posedge clk_sys) disable iff (rst) state_ff == SAC_ST_WAKE);
  c_stuck: cover property (@(posedge clk_sys) disable iff (rst) st_conversion_start_strobe ##1 nap_mode);
endmodule

/* sac_host_model.sv */
// Host model: drives the three-wire link and collects the serial result
`timescale 1ns/100ps
module sac_host_model #(
  parameter int PH = 5
) (
  // Clock
  input  wire logic clk_sys,
  // Link to the converter
  output logic      conversion_start_strobe,
  output logic      link_clk,
  input  wire logic dout_data,
  input  wire logic dout_oe
);
  import sac_pkg::*;
  // Released pin floats, so a missing bit never reads as a match
  wire logic dout_w;
  assign dout_w = dout_oe ? dout_data : 1'bz;
  initial begin
    conversion_start_strobe = 1'b0;
    link_clk                = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic strobe;
    conversion_start_strobe = 1'b1;
    tick(1);
    conversion_start_strobe = 1'b0;
  endtask
  // twelve clocks, bit read late in high phase
  task automatic convert(input bit mid, output logic [11:0] bits);
    strobe();
    tick(4);
    for (int i = 0; i < 12; i++) begin
      link_clk = 1'b0;
      tick(PH);
      link_clk = 1'b1;
      if (mid && i == 5) begin
        tick(1);
        strobe();
        tick(PH - 2);
      end else begin
        tick(PH);
      end
      bits[11-i] = dout_w;
    end
    tick(PH);
  endtask
  task automatic pulses(input int n);
    link_clk = 1'b0;
    tick(3);
    repeat (n) begin
      strobe();
      tick(3);
    end
  endtask
  // gap, then a 300 ns clock pulse
  task automatic wake;
    tick(2);
    link_clk = 1'b1;
    tick(SAC_WAKE_PULSE_CYC + 2);
    link_clk = 1'b0;
    tick(10);
    link_clk = 1'b1;
    tick(3);
  endtask
endmodule

/* tb.sv */
// Self-checking bench of the converter control block
`timescale 1ns/100ps
module tb;
  import sac_pkg::*;
  // Reference settling after sleep wake-up, 4 ms
  localparam int SETTLE = 4000000 / SAC_CLK_PERIOD_NS;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        bipolar_mode = 1'b0;
  logic        cmp_decision;
  logic        strobe_w, lclk_w, dout_data, dout_oe;
  logic        track_mode, nap_mode, sleep_mode, conversion_start_strobe_busy, result_valid;
  logic [11:0] dac_code, result_word, bits, prev_exp;
  logic [11:0] vin = 12'h000;
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          rv_cnt = 0;
  int          seed = 32'hE42222CD;
  bit          prev_ok = 1'b0;
  always #50 clk_sys = ~clk_sys;
  // Comparator keeps a trial bit while the trial code is not above the input
  assign cmp_decision = (dac_code <= vin);
  sac_host_model hst (.clk_sys(clk_sys), .conversion_start_strobe(strobe_w), .link_clk(lclk_w),
                      .dout_data(dout_data), .dout_oe(dout_oe));
  sac_top dut (.clk_sys(clk_sys), .rst(rst), .conversion_start_strobe(strobe_w), .link_clk(lclk_w),
               .dout_data(dout_data), .dout_oe(dout_oe), .bipolar_mode(bipolar_mode),
               .cmp_decision(cmp_decision), .dac_code(dac_code), .track_mode(track_mode),
               .nap_mode(nap_mode), .sleep_mode(sleep_mode), .conversion_start_strobe_busy(conversion_start_strobe_busy),
               .result_valid(result_valid), .result_word(result_word));
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [11:0] exp_code(input logic [11:0] v, input logic bip);
    return bip ? (v ^ SAC_SIGN_FLIP) : v;
  endfunction
  task automatic wrap_up;
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (result_valid === 1'b1) begin
      rv_cnt++;
      check("track after end", 12'h001, {11'h000, track_mode});
      check("busy after end", 12'h000, {11'h000, conversion_start_strobe_busy});
    end
    // Ceiling covers the 4 ms settle plus every conversion
    if (cyc == 50000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic do_conversion_start_strobe(input logic [11:0] v, input logic bip, input bit mid);
    int n0;
    n0 = rv_cnt;
    vin = v;
    bipolar_mode = bip;
    fork
      hst.convert(mid, bits);
      begin
        tick(5);
        check("busy", 12'h001, {11'h000, conversion_start_strobe_busy});
        check("track", 12'h000, {11'h000, track_mode});
      end
    join
    check("valid count", 12'(n0 + 1), 12'(rv_cnt));
    check("result", exp_code(v, bip), result_word);
    if (prev_ok) check("serial", prev_exp, bits);
    prev_exp = exp_code(v, bip);
    prev_ok = 1'b1;
  endtask
  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    tick(6);
    rst = 1'b0;
    tick(4);
    check("reset oe", 12'h000, {11'h000, dout_oe});
    check("reset track", 12'h001, {11'h000, track_mode});
    check("reset result", 12'h000, result_word);
    do_conversion_start_strobe(12'h000, 1'b0, 1'b0);
    do_conversion_start_strobe(12'hFFF, 1'b0, 1'b0);
    do_conversion_start_strobe(12'h7FF, 1'b1, 1'b0);
    do_conversion_start_strobe(12'h800, 1'b1, 1'b0);
    do_conversion_start_strobe(12'hA5A, 1'b0, 1'b1);
    repeat (8) do_conversion_start_strobe(12'($random(seed)), 1'($random(seed)), 1'b0);
    hst.pulses(2);
    tick(4);
    check("nap", 12'h001, {11'h000, nap_mode});
    prev_ok = 1'b0;
    fork
      hst.wake();
      begin
        tick(2 + 3 + 3 + SAC_WAKE_NAP_CYC + 2);
        check("nap wake", 12'h001, {11'h000, track_mode});
        check("nap left", 12'h000, {11'h000, nap_mode});
      end
    join
    do_conversion_start_strobe(12'($random(seed)), 1'b0, 1'b0);
    // abandoned conversion recovered through a nap request
    hst.strobe();
    tick(6);
    check("stuck busy", 12'h001, {11'h000, conversion_start_strobe_busy});
    hst.pulses(2);
    tick(4);
    check("stuck nap", 12'h001, {11'h000, nap_mode});
    prev_ok = 1'b0;
    hst.wake();
    do_conversion_start_strobe(12'h5A5, 1'b1, 1'b0);
    hst.pulses(4);
    tick(4);
    check("sleep", 12'h001, {11'h000, sleep_mode});
    prev_ok = 1'b0;
    hst.wake();
    tick(SETTLE);
    do_conversion_start_strobe(12'h3C3, 1'b1, 1'b0);
    do_conversion_start_strobe(12'h001, 1'b0, 1'b0);
    wrap_up();
  end
endmodule
